//--- design/rcc_pkg.sv
// Package with register map, field layout and reset values of the radio config bank.
package rcc_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [6:0] RCC_IDX_BUFFER  = 7'h00;
    localparam logic [6:0] RCC_IDX_MODE    = 7'h01;
    localparam logic [6:0] RCC_IDX_RATE_HI = 7'h02;
    localparam logic [6:0] RCC_IDX_RATE_LO = 7'h03;
    localparam logic [6:0] RCC_IDX_DEV_HI  = 7'h04;
    localparam logic [6:0] RCC_IDX_DEV_LO  = 7'h05;
    localparam logic [6:0] RCC_IDX_CAR_HI  = 7'h06;
    localparam logic [6:0] RCC_IDX_CAR_MID = 7'h07;
    localparam logic [6:0] RCC_IDX_CAR_LO  = 7'h08;
    localparam logic [6:0] RCC_IDX_STATUS2 = 7'h3f;
    localparam logic [6:0] RCC_IDX_PINMAP1 = 7'h40;
    localparam logic [6:0] RCC_IDX_PINMAP2 = 7'h41;
    localparam logic [6:0] RCC_IDX_REV     = 7'h42;
    localparam logic [6:0] RCC_IDX_GREF    = 7'h43;
    localparam logic [6:0] RCC_IDX_GTH1    = 7'h44;
    localparam logic [6:0] RCC_IDX_GTH2    = 7'h45;
    localparam logic [6:0] RCC_IDX_GTH3    = 7'h46;
    localparam logic [6:0] RCC_IDX_REFSEL  = 7'h58;
    localparam logic [6:0] RCC_IDX_AMPHI   = 7'h5a;
    localparam logic [6:0] RCC_IDX_LOOPBW  = 7'h5c;
    localparam logic [6:0] RCC_IDX_QLOOPBW = 7'h5e;
    localparam logic [6:0] RCC_IDX_CALTEMP = 7'h6c;
    localparam logic [6:0] RCC_IDX_FRAC    = 7'h70;
    localparam logic [6:0] RCC_IDX_CARAPP  = 7'h7f;
    // Built-in reset values.
    localparam logic [7:0] RCC_RST_BUFFER  = 8'h00;
    localparam logic [7:0] RCC_RST_MODE    = 8'h01;
    localparam logic [7:0] RCC_RST_RATE_HI = 8'h1a;
    localparam logic [7:0] RCC_RST_RATE_LO = 8'h0b;
    localparam logic [7:0] RCC_RST_DEV_HI  = 8'h00;
    localparam logic [7:0] RCC_RST_DEV_LO  = 8'h52;
    localparam logic [7:0] RCC_RST_CAR_HI  = 8'he4;
    localparam logic [7:0] RCC_RST_CAR_MID = 8'hc0;
    localparam logic [7:0] RCC_RST_CAR_LO  = 8'h00;
    localparam logic [7:0] RCC_RST_PINMAP  = 8'h00;
    localparam logic [7:0] RCC_RST_GREF    = 8'h13;
    localparam logic [7:0] RCC_RST_GTH1    = 8'h0e;
    localparam logic [7:0] RCC_RST_GTH2    = 8'h5b;
    localparam logic [7:0] RCC_RST_GTH3    = 8'hdb;
    localparam logic [7:0] RCC_RST_REFSEL  = 8'h09;
    localparam logic [7:0] RCC_RST_AMPHI   = 8'h84;
    localparam logic [7:0] RCC_RST_LOOPBW  = 8'hd0;
    localparam logic [7:0] RCC_RST_FRAC    = 8'h00;
    // Revision code: the value is arbitrary.
    localparam logic [7:0] RCC_REVISION    = 8'h5a;
    // Mode register field positions and masks, plus the deviation high and fraction masks.
    localparam int         RCC_MODE_LSB    = 0;
    localparam int         RCC_FILT_LSB    = 3;
    localparam int         RCC_KEY_LSB     = 5;
    localparam logic [7:0] RCC_MODE_WMASK  = 8'h7f;
    localparam logic [7:0] RCC_DEV_HI_MASK = 8'h3f;
    localparam logic [3:0] RCC_FRAC_MASK   = 4'hf;
    // Status two: buffer empty bit 6, full bit 7.
    localparam int         RCC_ST_EMPTY    = 6;
    localparam int         RCC_ST_FULL     = 7;
    localparam int         RCC_BUF_DEPTH   = 64;
    localparam logic [1:0] RCC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RCC_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        RCC_ST_SLEEP   = 3'b000,
        RCC_ST_STANDBY = 3'b001,
        RCC_ST_TXSYN   = 3'b010,
        RCC_ST_TX      = 3'b011,
        RCC_ST_RXSYN   = 3'b100,
        RCC_ST_RX      = 3'b101
    } rcc_opstate_t;

    typedef enum logic [1:0] {
        RCC_KEY_FSK = 2'b00,
        RCC_KEY_OOK = 2'b01
    } rcc_keying_t;

    // Settings delivered to the radio core.
    typedef struct packed {
        logic [2:0]  op_state;
        logic [1:0]  keying_select;
        logic [1:0]  pulse_filter_select;
        logic [15:0] rate_divisor;
        logic [3:0]  rate_fraction_field;
        logic [13:0] deviation;
        logic [23:0] carrier_applied;
        logic [7:0]  pin_map_one;
        logic [7:0]  pin_map_two;
    } rcc_cfg_t;
endpackage

//--- design/rcc_regs.sv
// AXI4-Lite register bank for the radio common configuration.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcc_regs
    import rcc_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [8:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [8:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Radio core side.
    output rcc_cfg_t         cfg,
    input  wire logic        rx_restart,
    input  wire logic [7:0]  cal_temperature
);

    // Write address and data are latched separately so either may come first.
    logic       aw_held;
    logic       w_held;
    logic [6:0] aw_idx;
    logic [7:0] w_byte;
    logic       w_lane0;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire       aw_take  = s_axi_awvalid && s_axi_awready;
    wire       w_take   = s_axi_wvalid && s_axi_wready;
    wire       aw_have  = aw_held || aw_take;
    wire       w_have   = w_held || w_take;
    wire       wr_go    = aw_have && w_have;
    wire [6:0] wr_idx   = aw_held ? aw_idx : s_axi_awaddr[8:2];
    wire [7:0] wr_byte  = w_held ? w_byte : s_axi_wdata[7:0];
    wire       wr_lane  = w_held ? w_lane0 : s_axi_wstrb[0];
    wire       wr_en    = wr_go && wr_lane;

    // Decode shared by the write response and the read response.
    function automatic logic rcc_mapped(input logic [6:0] idx);
        case (idx)
            RCC_IDX_BUFFER, RCC_IDX_MODE, RCC_IDX_RATE_HI, RCC_IDX_RATE_LO,
            RCC_IDX_DEV_HI, RCC_IDX_DEV_LO, RCC_IDX_CAR_HI, RCC_IDX_CAR_MID,
            RCC_IDX_CAR_LO, RCC_IDX_STATUS2, RCC_IDX_PINMAP1, RCC_IDX_PINMAP2,
            RCC_IDX_REV, RCC_IDX_GREF, RCC_IDX_GTH1, RCC_IDX_GTH2, RCC_IDX_GTH3,
            RCC_IDX_REFSEL, RCC_IDX_AMPHI, RCC_IDX_LOOPBW, RCC_IDX_QLOOPBW,
            RCC_IDX_CALTEMP, RCC_IDX_FRAC, RCC_IDX_CARAPP:
                rcc_mapped = 1'b1;
            default:
                rcc_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic rcc_hit(input logic [6:0] idx, input logic [6:0] want);
        rcc_hit = (idx == want);
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= 7'h00;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else
        begin
            aw_held <= aw_have && !wr_go;
            w_held  <= w_have && !wr_go;
            if (aw_take)
                aw_idx <= s_axi_awaddr[8:2];
            if (w_take)
            begin
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // Write response; unmapped or read-only targets answer SLVERR.
    wire wr_ro = rcc_hit(wr_idx, RCC_IDX_STATUS2) || rcc_hit(wr_idx, RCC_IDX_REV) ||
                 rcc_hit(wr_idx, RCC_IDX_CALTEMP) || rcc_hit(wr_idx, RCC_IDX_CARAPP);
    wire wr_err = !rcc_mapped(wr_idx) || wr_ro;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RCC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? RCC_RESP_SLVERR : RCC_RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Configuration registers, all reloaded on reset.
    logic [7:0] mode_reg;
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [5:0] dev_hi;
    logic [7:0] dev_lo;
    logic [7:0] car_hi;
    logic [7:0] car_mid;
    logic [7:0] car_lo;
    logic [7:0] pin_map1;
    logic [7:0] pin_map2;
    logic [7:0] gain_ref;
    logic [7:0] gain_th1;
    logic [7:0] gain_th2;
    logic [7:0] gain_th3;
    logic [7:0] ref_sel;
    logic [7:0] amp_hi;
    logic [7:0] loop_bw;
    logic [7:0] qloop_bw;
    logic [3:0] frac_reg;
    logic [23:0] car_applied;

    // The carrier word is staged; the core sees it only after an apply event.
    wire [2:0] new_state  = wr_byte[RCC_MODE_LSB +: 3];
    wire       mode_wr    = wr_en && rcc_hit(wr_idx, RCC_IDX_MODE);
    wire       syn_entry  = mode_wr && (new_state == RCC_ST_TXSYN || new_state == RCC_ST_RXSYN)
                            && (new_state != mode_reg[2:0]);
    wire       car_apply  = syn_entry || rx_restart;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg <= RCC_RST_MODE;
            rate_hi  <= RCC_RST_RATE_HI;
            rate_lo  <= RCC_RST_RATE_LO;
            dev_hi   <= RCC_RST_DEV_HI[5:0];
            dev_lo   <= RCC_RST_DEV_LO;
            car_hi   <= RCC_RST_CAR_HI;
            car_mid  <= RCC_RST_CAR_MID;
            car_lo   <= RCC_RST_CAR_LO;
            pin_map1 <= RCC_RST_PINMAP;
            pin_map2 <= RCC_RST_PINMAP;
            gain_ref <= RCC_RST_GREF;
            gain_th1 <= RCC_RST_GTH1;
            gain_th2 <= RCC_RST_GTH2;
            gain_th3 <= RCC_RST_GTH3;
            ref_sel  <= RCC_RST_REFSEL;
            amp_hi   <= RCC_RST_AMPHI;
            loop_bw  <= RCC_RST_LOOPBW;
            qloop_bw <= RCC_RST_LOOPBW;
            frac_reg <= RCC_RST_FRAC[3:0];
            car_applied <= {RCC_RST_CAR_HI, RCC_RST_CAR_MID, RCC_RST_CAR_LO};
        end
        else
        begin
            if (mode_wr)
                mode_reg <= wr_byte & RCC_MODE_WMASK;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_RATE_HI))
                rate_hi <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_RATE_LO))
                rate_lo <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_DEV_HI))
                dev_hi <= wr_byte[5:0];
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_DEV_LO))
                dev_lo <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_CAR_HI))
                car_hi <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_CAR_MID))
                car_mid <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_CAR_LO))
                car_lo <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_PINMAP1))
                pin_map1 <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_PINMAP2))
                pin_map2 <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_GREF))
                gain_ref <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_GTH1))
                gain_th1 <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_GTH2))
                gain_th2 <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_GTH3))
                gain_th3 <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_REFSEL))
                ref_sel <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_AMPHI))
                amp_hi <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_LOOPBW))
                loop_bw <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_QLOOPBW))
                qloop_bw <= wr_byte;
            if (wr_en && rcc_hit(wr_idx, RCC_IDX_FRAC))
                frac_reg <= wr_byte[3:0] & RCC_FRAC_MASK;
            // The staged word includes a write to the high byte in the same cycle as the apply; middle and low bytes do not.
            if (car_apply)
                car_applied <= {wr_en && rcc_hit(wr_idx, RCC_IDX_CAR_HI) ? wr_byte : car_hi,
                                car_mid, car_lo};
        end
    end

    // Packet buffer: a circular store of bytes behind offset 0x00.
    logic [7:0] buf_mem [RCC_BUF_DEPTH];
    logic [5:0] buf_wp;
    logic [5:0] buf_rp;
    logic [6:0] buf_cnt;

    wire buf_empty = (buf_cnt == 7'd0);
    wire buf_full  = (buf_cnt == 7'(RCC_BUF_DEPTH));
    wire ar_take;
    wire [6:0] rd_idx = s_axi_araddr[8:2];
    wire buf_push  = wr_en && rcc_hit(wr_idx, RCC_IDX_BUFFER) && !buf_full;
    wire buf_pop   = ar_take && rcc_hit(rd_idx, RCC_IDX_BUFFER) && !buf_empty;

    always_ff @(posedge aclk)
    begin
        if (buf_push)
            buf_mem[buf_wp] <= wr_byte;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            buf_wp  <= 6'd0;
            buf_rp  <= 6'd0;
            buf_cnt <= 7'd0;
        end
        else
        begin
            if (buf_push)
                buf_wp <= buf_wp + 6'd1;
            if (buf_pop)
                buf_rp <= buf_rp + 6'd1;
            buf_cnt <= buf_cnt + 7'(buf_push) - 7'(buf_pop);
        end
    end

    // Read path; unused bits return zero.
    wire [7:0] status2 = {buf_full, buf_empty, 6'h00};
    logic [7:0] rd_byte;

    always_comb
    begin
        case (rd_idx)
            RCC_IDX_BUFFER:  rd_byte = buf_empty ? 8'h00 : buf_mem[buf_rp];
            RCC_IDX_MODE:    rd_byte = mode_reg;
            RCC_IDX_RATE_HI: rd_byte = rate_hi;
            RCC_IDX_RATE_LO: rd_byte = rate_lo;
            RCC_IDX_DEV_HI:  rd_byte = {2'b00, dev_hi};
            RCC_IDX_DEV_LO:  rd_byte = dev_lo;
            RCC_IDX_CAR_HI:  rd_byte = car_hi;
            RCC_IDX_CAR_MID: rd_byte = car_mid;
            RCC_IDX_CAR_LO:  rd_byte = car_lo;
            RCC_IDX_STATUS2: rd_byte = status2;
            RCC_IDX_PINMAP1: rd_byte = pin_map1;
            RCC_IDX_PINMAP2: rd_byte = pin_map2;
            RCC_IDX_REV:     rd_byte = RCC_REVISION;
            RCC_IDX_GREF:    rd_byte = gain_ref;
            RCC_IDX_GTH1:    rd_byte = gain_th1;
            RCC_IDX_GTH2:    rd_byte = gain_th2;
            RCC_IDX_GTH3:    rd_byte = gain_th3;
            RCC_IDX_REFSEL:  rd_byte = ref_sel;
            RCC_IDX_AMPHI:   rd_byte = amp_hi;
            RCC_IDX_LOOPBW:  rd_byte = loop_bw;
            RCC_IDX_QLOOPBW: rd_byte = qloop_bw;
            RCC_IDX_CALTEMP: rd_byte = cal_temperature;
            RCC_IDX_FRAC:    rd_byte = {4'h0, frac_reg};
            RCC_IDX_CARAPP:  rd_byte = car_applied[23:16];
            default:         rd_byte = 8'h00;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RCC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rcc_mapped(rd_idx) ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Settings to the core; the rate is crystal over divisor plus fraction/16.
    assign cfg = '{
        op_state:            mode_reg[RCC_MODE_LSB +: 3],
        keying_select:       mode_reg[RCC_KEY_LSB +: 2],
        pulse_filter_select: mode_reg[RCC_FILT_LSB +: 2],
        rate_divisor:        {rate_hi, rate_lo},
        rate_fraction_field: frac_reg,
        deviation:           {dev_hi, dev_lo},
        carrier_applied:     car_applied,
        pin_map_one:         pin_map1,
        pin_map_two:         pin_map2
    };

    AST_RESET_MODE: assert property (@(posedge aclk)
        !aresetn |=> mode_reg == RCC_RST_MODE && rate_hi == RCC_RST_RATE_HI)
        else $error("Mode or rate not reloaded by reset.");
    AST_MODE_BIT7: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_reg[7] == 1'b0)
        else $error("Mode bit 7 set.");
    AST_DEV_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_idx == RCC_IDX_DEV_HI |=> s_axi_rdata[7:6] == 2'b00)
        else $error("Deviation high unused bits read nonzero.");
    AST_REV_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_idx == RCC_IDX_REV |=> s_axi_rdata[7:0] == RCC_REVISION)
        else $error("Revision register changed.");
    AST_RATE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == RCC_IDX_RATE_LO |=> cfg.rate_divisor[7:0] == $past(wr_byte))
        else $error("Rate low byte not stored.");
    AST_CAR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !car_apply |=> $stable(cfg.carrier_applied))
        else $error("Carrier changed without apply event.");
    AST_BUF_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
        buf_push && !buf_pop |=> buf_cnt == $past(buf_cnt) + 7'd1)
        else $error("Buffer write did not push.");
    AST_BUF_POP: assert property (@(posedge aclk) disable iff (!aresetn)
        buf_pop && !buf_push |=> buf_cnt == $past(buf_cnt) - 7'd1)
        else $error("Buffer read did not pop.");
    AST_MAP_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == RCC_IDX_PINMAP2 |=> cfg.pin_map_two == $past(wr_byte))
        else $error("Pin map two not stored.");
    AST_FRAC_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == RCC_IDX_FRAC |=> cfg.rate_fraction_field == $past(wr_byte[3:0]))
        else $error("Fraction not stored.");

    // Field and apply checks on what the core sees after a write.
    AST_DEV_HI_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == RCC_IDX_DEV_HI |=> cfg.deviation[13:8] == $past(wr_byte[5:0]))
        else $error("Deviation high bits not stored.");
    AST_MODE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_wr |=> cfg.op_state == $past(new_state))
        else $error("Operating state not stored.");
    AST_KEY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_wr |=> cfg.keying_select == $past(wr_byte[RCC_KEY_LSB +: 2]))
        else $error("Keying selection not stored.");
    AST_CAR_SYNTH: assert property (@(posedge aclk) disable iff (!aresetn)
        syn_entry |=> cfg.carrier_applied == {car_hi, car_mid, car_lo})
        else $error("Carrier word not applied on synthesizer entry.");

endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the radio configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcc_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [8:0]  awaddr = 9'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [8:0]  araddr = 9'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    rcc_cfg_t    cfg;
    logic        rx_restart = 1'b0;
    logic [7:0]  cal_temp = 8'h3c;
    logic [31:0] rd_data;
    logic [1:0]  last_resp;
    logic [7:0]  m;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [6:0]  rst_idx [13] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h44, 7'h45,
                                  7'h46, 7'h5c, 7'h5e, 7'h70, 7'h3f, 7'h40};
    logic [7:0]  rst_val [13] = '{8'h01, 8'h1a, 8'h0b, 8'h00, 8'h52, 8'h0e, 8'h5b,
                                  8'hdb, 8'hd0, 8'hd0, 8'h00, 8'h40, 8'h00};

    rcc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cfg(cfg), .rx_restart(rx_restart),
        .cal_temperature(cal_temp));

    // Free-running 20 MHz clock.
    always #25 aclk = ~aclk;

    // Hang guard: the whole sequence needs well under a thousand cycles.
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // Ready is sampled at the falling edge, where it is settled, and acted on at the next rise.
    task automatic wr(input logic [6:0] idx, input logic [7:0] val);
        logic ad;
        logic wd;
        logic b;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, val};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            ad = ad | (awready & awvalid);
            wd = wd | (wready & wvalid);
            @(posedge aclk);
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end while (!(ad && wd));
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            b = bvalid;
            last_resp = bresp;
            @(posedge aclk);
        end while (!b);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] idx);
        logic a;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            a = arready;
            @(posedge aclk);
        end while (!a);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            a = rvalid;
            rd_data = rdata;
            last_resp = rresp;
            @(posedge aclk);
        end while (!a);
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [6:0] idx, input logic [7:0] exp);
        rd(idx);
        chk("read data", {24'h0, exp}, rd_data);
    endtask

    task automatic reset_and_check();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_idx[i])
            rc(rst_idx[i], rst_val[i]);
        $display("reset values test done");
    endtask

    // Main sequence.
    initial
    begin
        reset_and_check();
        for (int i = 0; i < 8; i++)
        begin
            m = {2'b00, i[2], i[1:0], 3'(i % 6)};
            wr(7'h01, m);
            rc(7'h01, m);
            chk("mode cfg", {m[2:0], m[6:5], m[4:3]},
                {cfg.op_state, cfg.keying_select, cfg.pulse_filter_select});
        end
        wr(7'h01, 8'hff);
        rc(7'h01, 8'h7f);
        $display("mode test done");
        wr(7'h02, 8'h12);
        wr(7'h03, 8'h34);
        chk("write resp", 32'h0, last_resp);
        wr(7'h70, 8'hf5);
        chk("divisor", 32'h1234, cfg.rate_divisor);
        chk("fraction", 32'h5, cfg.rate_fraction_field);
        rc(7'h70, 8'h05);
        wr(7'h04, 8'hff);
        wr(7'h05, 8'ha5);
        rc(7'h04, 8'h3f);
        chk("deviation", 32'h3fa5, cfg.deviation);
        $display("rate and deviation test done");
        wr(7'h00, 8'h11);
        wr(7'h00, 8'h22);
        rc(7'h3f, 8'h00);
        rc(7'h00, 8'h11);
        rc(7'h00, 8'h22);
        rc(7'h3f, 8'h40);
        rc(7'h00, 8'h00);
        $display("buffer test done");
        wr(7'h40, 8'ha5);
        wr(7'h41, 8'h3c);
        chk("pin maps", 32'ha53c, {cfg.pin_map_one, cfg.pin_map_two});
        rc(7'h41, 8'h3c);
        chk("read resp", 32'h0, last_resp);
        // Read-only and unmapped offsets are written; both answer SLVERR and stay unchanged.
        wr(7'h42, 8'hff);
        chk("revision write resp", 32'h2, last_resp);
        rc(7'h42, 8'h5a);
        wr(7'h10, 8'hff);
        chk("unmapped write resp", 32'h2, last_resp);
        rc(7'h10, 8'h00);
        chk("unmapped read resp", 32'h2, last_resp);
        rc(7'h6c, 8'h3c);
        $display("map test done");
        wr(7'h01, 8'h01);
        wr(7'h06, 8'h12);
        chk("carrier held", 32'he4c000, cfg.carrier_applied);
        @(posedge aclk);
        rx_restart <= 1'b1;
        @(posedge aclk);
        rx_restart <= 1'b0;
        @(negedge aclk);
        chk("carrier restart", 32'h12c000, cfg.carrier_applied);
        wr(7'h06, 8'h34);
        wr(7'h01, 8'h04);
        chk("carrier synth", 32'h34c000, cfg.carrier_applied);
        $display("carrier test done");
        reset_and_check();
        end_sim();
    end
endmodule
`default_nettype wire
